// ===== rtl/lsg_pkg.sv
// Shared constants and types for the panel signal generator
package lsg_pkg;
  // Data widths on the panel side
  localparam int unsigned STN_DATA_W  = 4;   // Column data nibble
  localparam int unsigned TFT_DATA_W  = 6;   // TFT pixel word
  localparam int unsigned GROUP_COLS  = 16;  // Shift clocks per enable-chain step
  localparam int unsigned GROUP_HALF  = 3;   // Column index bit that marks half a group
  // Geometry defaults
  localparam int unsigned DEF_LINE_GROUPS = 2;   // Column groups per line
  localparam int unsigned DEF_FRAME_LINES = 8;   // Lines per frame
  localparam int unsigned BUF_DEPTH       = 2;   // Entries in the input buffer
  // Power-save frame count before the disable output drops
  localparam logic [1:0]  PS_FRAMES       = 2'h2;
  // Reset values of the pins and counters
  localparam logic [5:0]  DATA_RST        = 6'h00;
  localparam logic [7:0]  BIAS_CNT_RST    = 8'h00;

  // Line sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_LATCH = 2'b10,
    ST_GAP   = 2'b11
  } lsg_state_t;
endpackage

// ===== rtl/lsg_edge_sync.sv
// Two-stage synchroniser with rise and fall detection for the link clock
module lsg_edge_sync (
  // Clocking
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Asynchronous level in
  input  wire logic async_in,
  // Edge pulses out
  output logic      rise,
  output logic      fall
);
  logic meta_reg;   // First stage, read only by the second
  logic sync_reg;   // Second stage
  logic last_reg;   // Previous synchronised level

  // Synchroniser chain; edge detection looks at the second stage only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise = clk_en & sync_reg & ~last_reg;
  assign fall = clk_en & ~sync_reg & last_reg;
endmodule // lsg_edge_sync

// ===== rtl/lsg_skid_buf.sv
// Small valid/ready FIFO that absorbs receiver stalls without loss
module lsg_skid_buf #(
  parameter int unsigned W     = 6,
  parameter int unsigned DEPTH = 2
) (
  // Clocking
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem_reg [DEPTH];   // Storage entries
  logic [AW-1:0] wr_ptr_reg;        // Next slot to fill
  logic [AW-1:0] rd_ptr_reg;        // Oldest slot
  logic [AW:0]   count_reg;         // Occupancy
  logic [AW:0]   count_next;        // Occupancy after this cycle
  logic          in_ready_reg;      // Room for a word, held in a flop
  logic          push;
  logic          pop;

  // Ready comes from a flop so the port has no path through the occupancy logic
  assign in_ready  = in_ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Next occupancy; push and pop in one cycle leave it unchanged
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  // Pointers and occupancy; wrap at DEPTH
  // Ready stays low in reset and rises at the first edge after release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg    <= count_next;
      // Full when every entry holds a word
      in_ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule // lsg_skid_buf

// ===== rtl/lsg_panel_gen.sv
// Panel signal generator: STN driver control or TFT timing on shared pins
// Operation
// - Select bit one gives TFT, zero STN
// - Enable chain clock falls once per sixteen
// - STN column data on four low pins
// - TFT gives data, enable, clock, hsync, vsync
// - Bias toggle period set by host
// - One line latch pulse per line
// - Frame pulse active during last line
// - Column clocks per line multiple of sixteen
// - Shift clock stopped from latch to next line
// - Disable high when active in STN, low after power save; always low in TFT
// - Reset returns everything to inactive state
module lsg_panel_gen #(
  parameter int unsigned LINE_GROUPS = lsg_pkg::DEF_LINE_GROUPS,
  parameter int unsigned FRAME_LINES = lsg_pkg::DEF_FRAME_LINES
) (
  // Clock, reset, enable
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // Link timing reference from outside
  input  wire logic       link_clock,
  // Configuration from the controller
  input  wire logic       tft_select,
  input  wire logic [7:0] bias_lines,
  input  wire logic       power_save,
  // Pixel stream in
  input  wire logic       pix_valid,
  output logic            pix_ready,
  input  wire logic [5:0] pix_data,
  // Panel pins
  output logic [3:0]      panel_data,
  output logic            panel_data_bit4,
  output logic            panel_data_bit5,
  output logic            panel_data_enable,
  output logic            panel_line_sync,
  output logic            panel_frame_sync,
  output logic            panel_pixel_clock,
  output logic            display_disable
);
  localparam int unsigned LINE_COLS = LINE_GROUPS * lsg_pkg::GROUP_COLS;
  localparam int unsigned CW        = $clog2(LINE_COLS + 1);
  localparam int unsigned LW        = (FRAME_LINES > 1) ? $clog2(FRAME_LINES) : 1;

  lsg_pkg::lsg_state_t state_reg;     // Line sequencer state
  logic [CW-1:0]       col_cnt_reg;   // Columns shifted this line
  logic [LW-1:0]       line_cnt_reg;  // Current line in frame
  logic [5:0]          data_reg;      // Word on the data pins
  logic                sclk_reg;      // Column shift / pixel clock
  logic                ecl_reg;       // Enable chain clock
  logic                lp_reg;        // Line latch pulse / hsync
  logic                row_shift_clock_reg;      // Row shift clock
  logic                yd_reg;        // Frame pulse / vsync
  logic                den_reg;       // Data enable
  logic                bias_reg;      // Backplane bias toggle
  logic [7:0]          bias_cnt_reg;  // Lines since last bias toggle
  logic [1:0]          ps_cnt_reg;    // Frame ends seen in power save
  logic                dis_reg;       // Display enabled level
  // Pin registers
  logic [3:0]          pd_pin_reg;
  logic                b4_pin_reg;
  logic                b5_pin_reg;
  logic                den_pin_reg;
  logic                line_pin_reg;
  logic                frame_pin_reg;
  logic                pclk_pin_reg;
  logic                dis_pin_reg;
  // Internal strobes
  logic                tick_rise;
  logic                tick_fall;
  logic                buf_valid;
  logic [5:0]          buf_data;
  logic                buf_pop;
  logic                lp_fall;
  logic                frame_end;

  // Link clock edges become timing ticks
  lsg_edge_sync u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in (link_clock),
    .rise     (tick_rise),
    .fall     (tick_fall)
  );

  // Pixel words wait here so a stalled line loses nothing
  lsg_skid_buf #(
    .W     (lsg_pkg::TFT_DATA_W),
    .DEPTH (lsg_pkg::BUF_DEPTH)
  ) u_buf (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (pix_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  // A word leaves the buffer only on a rise tick of an unfinished line
  assign buf_pop   = (state_reg == lsg_pkg::ST_SHIFT) && tick_rise && buf_valid
                     && (col_cnt_reg != CW'(LINE_COLS));
  assign lp_fall   = (state_reg == lsg_pkg::ST_LATCH) && tick_fall && lp_reg;
  assign frame_end = lp_fall && (line_cnt_reg == LW'(FRAME_LINES - 1));

  // Line sequencer: shift columns, latch, short gap, next line
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg   <= lsg_pkg::ST_IDLE;
      col_cnt_reg <= '0;
    end else if (clk_en) begin
      case (state_reg)
        lsg_pkg::ST_IDLE: begin
          // Start on a clean tick so the first clock high is full width
          if (tick_rise) begin
            state_reg <= lsg_pkg::ST_SHIFT;
          end
        end
        lsg_pkg::ST_SHIFT: begin
          if (buf_pop) begin
            col_cnt_reg <= col_cnt_reg + CW'(1);
          end
          // Whole groups only, so the count is a multiple of sixteen
          if (tick_fall && col_cnt_reg == CW'(LINE_COLS)) begin
            state_reg <= lsg_pkg::ST_LATCH;
          end
        end
        lsg_pkg::ST_LATCH: begin
          if (lp_fall) begin
            state_reg   <= lsg_pkg::ST_GAP;
            col_cnt_reg <= '0;
          end
        end
        lsg_pkg::ST_GAP: begin
          if (tick_rise) begin
            state_reg <= lsg_pkg::ST_SHIFT;
          end
        end
        default: begin
          state_reg <= lsg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Column data and shift clock; clock only runs while words flow
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      data_reg <= lsg_pkg::DATA_RST;
      sclk_reg <= 1'b0;
      den_reg  <= 1'b0;
      ecl_reg  <= 1'b0;
    end else if (clk_en) begin
      if (buf_pop) begin
        data_reg <= buf_data;
        sclk_reg <= 1'b1;
        den_reg  <= 1'b1;
        // High for the first half of each group: one fall per sixteen
        ecl_reg  <= ~col_cnt_reg[lsg_pkg::GROUP_HALF];
      end else if (tick_fall) begin
        // Falling edge with data held stable for the column drivers
        sclk_reg <= 1'b0;
      end
      // No clock outside the shifting state saves power
      if (state_reg != lsg_pkg::ST_SHIFT) begin
        den_reg  <= 1'b0;
        sclk_reg <= 1'b0;
      end
    end
  end

  // Line latch pulse and row shift clock, one pulse per line
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lp_reg   <= 1'b0;
      row_shift_clock_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == lsg_pkg::ST_LATCH && tick_rise && !lp_reg) begin
        lp_reg   <= 1'b1;
        row_shift_clock_reg <= 1'b1;
      end else if (lp_fall) begin
        lp_reg   <= 1'b0;
        row_shift_clock_reg <= 1'b0;
      end
    end
  end

  // Line count and frame pulse; the pulse stays up through the last latch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      line_cnt_reg <= '0;
      yd_reg       <= 1'b0;
    end else if (clk_en && lp_fall) begin
      if (frame_end) begin
        line_cnt_reg <= '0;
        yd_reg       <= (FRAME_LINES == 1);
      end else begin
        line_cnt_reg <= line_cnt_reg + LW'(1);
        // Row drivers sample it on the falling row clock of this line
        yd_reg <= (line_cnt_reg + LW'(1) == LW'(FRAME_LINES - 1));
      end
    end
  end

  // Backplane bias toggles every bias_lines lines; zero means once per frame
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bias_reg     <= 1'b0;
      bias_cnt_reg <= lsg_pkg::BIAS_CNT_RST;
    end else if (clk_en && lp_fall) begin
      if (bias_lines == 8'h00) begin
        bias_cnt_reg <= lsg_pkg::BIAS_CNT_RST;
        if (frame_end) begin
          bias_reg <= ~bias_reg;
        end
      end else if (bias_cnt_reg + 8'h01 >= bias_lines) begin
        bias_cnt_reg <= lsg_pkg::BIAS_CNT_RST;
        bias_reg     <= ~bias_reg;
      end else begin
        bias_cnt_reg <= bias_cnt_reg + 8'h01;
      end
    end
  end

  // Display disable: drops at the second frame end after power save
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ps_cnt_reg <= lsg_pkg::PS_FRAMES;
      dis_reg    <= 1'b0;
    end else if (clk_en && frame_end) begin
      if (!power_save) begin
        ps_cnt_reg <= 2'h0;
        dis_reg    <= 1'b1;
      end else if (ps_cnt_reg != lsg_pkg::PS_FRAMES) begin
        ps_cnt_reg <= ps_cnt_reg + 2'h1;
        // Row drivers blank themselves once this goes low
        dis_reg    <= (ps_cnt_reg + 2'h1 != lsg_pkg::PS_FRAMES);
      end
    end
  end

  // Pin routing by interface select, registered so pins come from flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pd_pin_reg    <= 4'h0;
      b4_pin_reg    <= 1'b0;
      b5_pin_reg    <= 1'b0;
      den_pin_reg   <= 1'b0;
      line_pin_reg  <= 1'b0;
      frame_pin_reg <= 1'b0;
      pclk_pin_reg  <= 1'b0;
      dis_pin_reg   <= 1'b0;
    end else if (clk_en) begin
      pd_pin_reg    <= data_reg[lsg_pkg::STN_DATA_W-1:0];
      line_pin_reg  <= lp_reg;
      frame_pin_reg <= yd_reg;
      pclk_pin_reg  <= sclk_reg;
      if (tft_select) begin
        b4_pin_reg  <= data_reg[lsg_pkg::STN_DATA_W];
        b5_pin_reg  <= data_reg[lsg_pkg::STN_DATA_W + 1];
        den_pin_reg <= den_reg;
        dis_pin_reg <= 1'b0;
      end else begin
        b4_pin_reg  <= ecl_reg;
        b5_pin_reg  <= row_shift_clock_reg;
        den_pin_reg <= bias_reg;
        dis_pin_reg <= dis_reg;
      end
    end
  end

  assign panel_data        = pd_pin_reg;
  assign panel_data_bit4   = b4_pin_reg;
  assign panel_data_bit5   = b5_pin_reg;
  assign panel_data_enable = den_pin_reg;
  assign panel_line_sync   = line_pin_reg;
  assign panel_frame_sync  = frame_pin_reg;
  assign panel_pixel_clock = pclk_pin_reg;
  assign display_disable   = dis_pin_reg;

  // Checks on the generated timing
  AST_PIN_ROUTE: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !tft_select |=> panel_data_bit4 == $past(ecl_reg))
    else $error("enable chain clock not routed in STN mode");
  AST_ECL_SYNC: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(ecl_reg) |-> $rose(sclk_reg))
    else $error("enable chain clock moved without a shift clock");
  AST_COL_MULT: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(lp_reg) |-> col_cnt_reg == CW'(LINE_COLS))
    else $error("line latched with wrong column count");
  AST_SCLK_STOP: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg == lsg_pkg::ST_LATCH |-> !sclk_reg)
    else $error("shift clock running during latch");
  AST_DATA_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sclk_reg) |-> $stable(data_reg))
    else $error("column data changed at shift clock fall");
  AST_LP_WIDTH: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    $rose(lp_reg) |-> lp_reg [*2] ##[1:40] !lp_reg)
    else $error("line latch pulse width wrong");
  AST_YD_LAST: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(lp_reg) |-> yd_reg == (line_cnt_reg == LW'(FRAME_LINES - 1)))
    else $error("frame pulse not on last line");
  AST_BIAS_AT_LINE: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(bias_reg) |-> $past(lp_fall))
    else $error("bias toggled outside a line end");
  AST_DIS_DROP: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(dis_reg) |-> $past(frame_end) && $past(power_save))
    else $error("display disable dropped without power save");
  AST_RESET_PINS: assert property (@(posedge clock)
    sys_rst |=> panel_line_sync == 1'b0 && panel_pixel_clock == 1'b0 && display_disable == 1'b0)
    else $error("pins not inactive after reset");
  COV_LINE: cover property (@(posedge clock) disable iff (sys_rst) lp_fall);
  COV_FRAME: cover property (@(posedge clock) disable iff (sys_rst) frame_end && yd_reg);
  COV_PSAVE: cover property (@(posedge clock) disable iff (sys_rst) $fell(dis_reg));
  COV_TFT: cover property (@(posedge clock) disable iff (sys_rst) tft_select && buf_pop);
endmodule // lsg_panel_gen

// ===== tb/lsg_panel_model.sv
// Behavioural model of the row and column driver chips on the panel
module lsg_panel_model (
  // Sampling clock and pin mapping
  input wire logic       clock,
  input wire logic       tft_mode,
  // Panel pins
  input wire logic [3:0] panel_data,
  input wire logic       panel_data_bit4,
  input wire logic       panel_data_bit5,
  input wire logic       panel_data_enable,
  input wire logic       panel_line_sync,
  input wire logic       panel_frame_sync,
  input wire logic       panel_pixel_clock,
  input wire logic       display_disable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cap [0:255];     // Ring of captured column words
  int         cap_n    = 0;    // Words captured so far
  int         line_n   = 0;    // Latch pulse falls seen
  int         cols     = 0;    // Shift clock falls in the running line
  int         cols_line = 0;   // Shift clock falls in the last whole line
  int         ecl      = 0;    // Chain clock falls in the running line
  int         ecl_line = 0;    // Chain clock falls in the last whole line
  int         frm_hits = 0;    // Frame pulses taken by the row drivers
  int         frm_line = 0;    // Line count at the last frame pulse
  int         frm_gap  = 0;    // Lines between the last two frame pulses
  int         bias_tog = 0;    // Bias toggle edges seen
  int         stop_err = 0;    // Shift clock edges during a latch pulse
  logic       row_blank = 1'b0; // Row outputs held at the blanking level
  logic [5:0] prev_word = 6'h00;
  logic       prev_pclk = 1'b0;
  logic       prev_den  = 1'b0;
  logic       prev_row  = 1'b0;
  logic       prev_line = 1'b0;
  logic       prev_frm  = 1'b0;

  // Pins launch on the rising edge, so the falling edge sees them settled;
  // captures use the value before the edge, as a real hold time allows
  always @(negedge clock) begin
    if (prev_pclk && !panel_pixel_clock && (!tft_mode || prev_den)) begin
      cap[cap_n % 256] = tft_mode ? prev_word : {2'b00, prev_word[3:0]};
      cap_n++;
      cols++;
    end
    if (panel_line_sync === 1'b1 && panel_pixel_clock !== prev_pclk) begin
      stop_err++;
    end
    if (!tft_mode && prev_word[4] && !panel_data_bit4) begin
      ecl++;
    end
    // Row drivers shift the frame pulse in on the row clock fall
    if (!tft_mode && prev_row && !panel_data_bit5 && prev_frm) begin
      frm_hits++;
      frm_gap = line_n - frm_line;
      frm_line = line_n;
    end
    if (prev_line && !panel_line_sync) begin
      line_n++;
      cols_line = cols;
      cols = 0;
      ecl_line = ecl;
      ecl = 0;
    end
    if (!tft_mode && panel_data_enable !== prev_den) begin
      bias_tog++;
    end
    row_blank = !tft_mode && display_disable === 1'b0;
    prev_word = {panel_data_bit5, panel_data_bit4, panel_data};
    prev_pclk = panel_pixel_clock;
    prev_den  = panel_data_enable;
    prev_row  = panel_data_bit5;
    prev_line = panel_line_sync;
    prev_frm  = panel_frame_sync;
  end
endmodule // lsg_panel_model

// ===== tb/lsg_panel_gen_test.sv
// Self-checking bench for the panel signal generator
module lsg_panel_gen_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int COLS  = 32;   // Two groups of sixteen columns
  localparam int FRAME = 8;    // Lines per frame in this bench
  // Design inputs
  logic       clock      = 1'b0;
  logic       sys_rst    = 1'b1;
  logic       clk_en     = 1'b1;
  logic       link_clock = 1'b0;
  logic       tft_select = 1'b0;
  logic [7:0] bias_lines = 8'h02;
  logic       power_save = 1'b0;
  logic       pix_valid  = 1'b0;
  logic [5:0] pix_data   = 6'h00;
  // Design outputs
  logic       pix_ready;
  logic [3:0] panel_data;
  logic       panel_data_bit4, panel_data_bit5, panel_data_enable, panel_line_sync;
  logic       panel_frame_sync, panel_pixel_clock, display_disable;
  // Bookkeeping
  int         miscompares = 0;
  int         compares    = 0;
  logic       saw_full    = 1'b0; // Buffer seen refusing a word

  always #25 clock = ~clock;
  // Link reference, phase unrelated to the system clock
  initial #137 forever #200 link_clock = ~link_clock;

  lsg_panel_gen #(.LINE_GROUPS(2), .FRAME_LINES(FRAME)) DUT (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .link_clock(link_clock),
    .tft_select(tft_select), .bias_lines(bias_lines), .power_save(power_save),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
    .panel_data(panel_data), .panel_data_bit4(panel_data_bit4), .panel_data_bit5(panel_data_bit5),
    .panel_data_enable(panel_data_enable), .panel_line_sync(panel_line_sync),
    .panel_frame_sync(panel_frame_sync), .panel_pixel_clock(panel_pixel_clock),
    .display_disable(display_disable)
  );

  lsg_panel_model pm (
    .clock(clock), .tft_mode(tft_select), .panel_data(panel_data),
    .panel_data_bit4(panel_data_bit4), .panel_data_bit5(panel_data_bit5),
    .panel_data_enable(panel_data_enable), .panel_line_sync(panel_line_sync),
    .panel_frame_sync(panel_frame_sync), .panel_pixel_clock(panel_pixel_clock),
    .display_disable(display_disable)
  );

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts and verdict, then stop
  task automatic results();
    $display("Checks %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hold reset for n cycles; every pin must be low at the last of them
  task automatic pulse_reset(input int n);
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (n) @(negedge clock);
    check("pins in reset", {panel_data, panel_data_bit4, panel_data_bit5, panel_data_enable,
          panel_line_sync, panel_frame_sync, panel_pixel_clock, display_disable}, 32'h0000_0000);
    sys_rst = 1'b0;
  endtask

  // Offer n whole lines of counting words, gap idle cycles after each, then
  // wait for the n-th latch pulse; a word is held until it is taken
  task automatic run_lines(input int n, input logic [5:0] base, input int gap);
    int i = 0;
    int tries = 0;
    int l0 = pm.line_n;
    while (i < n * COLS && tries < 40000) begin
      @(negedge clock);
      tries++;
      pix_valid = 1'b1;
      pix_data = base + i[5:0];
      #1;
      if (pix_ready === 1'b1) begin
        i++;
        if (gap > 0) begin
          @(negedge clock);
          pix_valid = 1'b0;
          repeat (gap - 1) @(negedge clock);
        end
      end else begin
        saw_full = 1'b1;
      end
    end
    @(negedge clock);
    pix_valid = 1'b0;
    tries = 0;
    while (pm.line_n < l0 + n && tries < 20000) begin
      @(posedge clock);
      tries++;
    end
    check("latch pulses", pm.line_n - l0, n);
  endtask

  // Captured words against the counting sequence
  task automatic check_words(input int c0, input logic [5:0] base, input int n, input logic [5:0] mask);
    for (int k = 0; k < n; k++) begin
      check("column word", pm.cap[(c0 + k) % 256], (base + k[5:0]) & mask);
    end
  endtask

  // Back-to-back STN lines at full rate, then one with a starved stream
  task automatic t_stn_lines();
    int c0 = pm.cap_n;
    int s0 = pm.stop_err;
    run_lines(2, 6'h05, 0);
    check_words(c0, 6'h05, 2 * COLS, 6'h0f);
    check("columns per line", pm.cols_line, COLS);
    check("chain falls per line", pm.ecl_line, COLS / 16);
    check("buffer refused when full", saw_full, 1'b1);
    c0 = pm.cap_n;
    run_lines(1, 6'h2a, 20);
    check_words(c0, 6'h2a, COLS, 6'h0f);
    check("columns stalled line", pm.cols_line, COLS);
    check("shift clock idle in latch", pm.stop_err - s0, 0);
  endtask

  // Two frames, bias toggling every second line
  task automatic t_frame();
    int b0 = pm.bias_tog;
    int f0 = pm.frm_hits;
    run_lines(2 * FRAME, 6'h11, 0);
    check("bias toggles", pm.bias_tog - b0, FRAME);
    check("frame pulses", pm.frm_hits - f0, 2);
    check("lines between frame pulses", pm.frm_gap, FRAME);
    check("display enabled", display_disable, 1'b1);
  endtask

  // Bias period zero: one toggle per frame
  task automatic t_bias0();
    int b0;
    @(negedge clock);
    bias_lines = 8'h00;
    run_lines(1, 6'h00, 0);
    b0 = pm.bias_tog;
    run_lines(2 * FRAME, 6'h07, 0);
    check("bias toggles per frame", pm.bias_tog - b0, 2);
  endtask

  // Power save blanks the rows within two frames, and is undone after
  task automatic t_power();
    @(negedge clock);
    power_save = 1'b1;
    run_lines(3 * FRAME, 6'h00, 0);
    check("display disabled", display_disable, 1'b0);
    check("rows blanked", pm.row_blank, 1'b1);
    @(negedge clock);
    power_save = 1'b0;
    run_lines(2 * FRAME, 6'h00, 0);
    check("display back on", display_disable, 1'b1);
    check("rows driven", pm.row_blank, 1'b0);
  endtask

  // TFT mapping: six data bits with enable and syncs on the same pins;
  // a whole frame runs so the internal enabled level is high while the pin must stay low
  task automatic t_tft();
    int c0;
    @(negedge clock);
    tft_select = 1'b1;
    pulse_reset(3);
    c0 = pm.cap_n;
    run_lines(FRAME, 6'h30, 0);
    check_words(c0, 6'h30, 2 * COLS, 6'h3f);
    check("disable unused in TFT", display_disable, 1'b0);
  endtask

  // Main sequence
  initial begin
    pulse_reset(12);
    t_stn_lines();
    t_frame();
    t_bias0();
    t_power();
    t_tft();
    results();
  end

  // Watchdog: the whole sequence needs well under 2 ms
  initial begin
    #4_000_000;
    miscompares++;
    results();
  end
endmodule // lsg_panel_gen_test
